// ### shared/bert_pkg.sv
// package: constants for the bit error rate test controller
package bert_pkg;
    localparam int unsigned CLK_HZ          = 250_000_000;
    localparam int unsigned CLK_PERIOD_NS   = 4;
    localparam int unsigned SECOND_NS       = 1_000_000_000;
    localparam int unsigned SECOND_CYCLES   = SECOND_NS / CLK_PERIOD_NS;
    localparam int unsigned PAT_MIN_LEN     = 3;
    localparam int unsigned PAT_MAX_LEN     = 200;
    localparam int unsigned MAX_DUR_HOURS   = 97;
    localparam int unsigned MAX_DUR_SECONDS = MAX_DUR_HOURS * 3600 + 59 * 60 + 59;
    localparam logic [31:0] OVF_LIMIT       = 32'h7735_9400;
    localparam logic [7:0]  RATE_NONE       = 8'h00;

    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_CMD       = 8'h01;
    localparam logic [7:0] ADDR_PAT_DATA  = 8'h02;
    localparam logic [7:0] ADDR_PAT_LAST  = 8'h03;
    localparam logic [7:0] ADDR_BLOCK_LEN = 8'h04;
    localparam logic [7:0] ADDR_DURATION  = 8'h05;
    localparam logic [7:0] ADDR_RATE      = 8'h06;
    localparam logic [7:0] ADDR_STATUS    = 8'h07;
    localparam logic [7:0] ADDR_ELAPSED   = 8'h08;
    localparam logic [7:0] ADDR_TX_BITS   = 8'h09;
    localparam logic [7:0] ADDR_TX_ERRS   = 8'h0a;
    localparam logic [7:0] ADDR_RX_BITS   = 8'h0b;
    localparam logic [7:0] ADDR_RX_ERRS   = 8'h0c;
    localparam logic [7:0] ADDR_SYNC_LOSS = 8'h0d;
    localparam logic [7:0] ADDR_PAT_PTR   = 8'h0e;

    localparam int unsigned CMD_SINGLE = 0;
    localparam int unsigned CMD_CONT   = 1;
    localparam int unsigned CMD_STOP   = 2;
    localparam int unsigned CMD_INSERR = 3;
    localparam int unsigned CMD_RESYNC = 4;
    localparam int unsigned CMD_RESET  = 5;
    localparam int unsigned CMD_SETUP  = 6;
    localparam int unsigned CMD_ERRTOG = 7;

    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_SYNC_FRM = 2;
    localparam int unsigned CTRL_CHAR5    = 3;

    localparam logic [15:0] BLOCK_LEN_RESET = 16'h0400;

    typedef enum logic [1:0] {
        MODE_REMOTE  = 2'b00,
        MODE_LOCAL   = 2'b01,
        MODE_RECEIVE = 2'b10
    } mode_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_NO_SYNC = 2'b01,
        ST_IN_SYNC = 2'b10
    } status_t;

    typedef enum logic [1:0] {
        RUN_OFF    = 2'b00,
        RUN_SINGLE = 2'b01,
        RUN_CONT   = 2'b10
    } run_t;
endpackage

// ### hw/stat_counter.sv
`timescale 1ns/10ps
// statistic counter with sticky overflow
module stat_counter #(
    parameter int W = 32
) (
    input  wire logic         clock,
    input  wire logic         reset_n,
    input  wire logic         clear,
    input  wire logic         inc,
    input  wire logic [W-1:0] limit,
    output logic      [W-1:0] count,
    output logic              overflow
);
    initial begin
        if (W < 32) $error("stat_counter width too small");
    end

    // saturates so the overflow flag cannot be undone by wrapping
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
        end else if (clear) begin
            count <= '0;
        end else if (inc && count != '1) begin
            count <= count + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            overflow <= 1'b0;
        end else if (clear) begin
            overflow <= 1'b0;
        end else if (count > limit) begin
            overflow <= 1'b1;
        end
    end
endmodule

// ### hw/bert_ctrl.sv
`timescale 1ns/10ps
// bit error rate test controller: pattern store, run sequencer, statistics
// Summary of operation
// - pattern length 3 to 200 bytes; other last-byte pointers are refused
// - writes past byte 200 wrap the write pointer to the first byte
// - last-byte pointer sets pattern length and follows each data write; one past sends whatever that byte already holds
// - 1-4 bit chars: data low, three zeros, ones above; 5 bits sit high
// - elapsed seconds restart on single, continuous, reset; halt on stop
// - status is idle, no sync or in sync; idle before start and after finish
// - without sync the receiver keeps retrying on its own
// - loopback single-block sends exactly one block of pattern
// - continuous: remote sends now, local once synced, receive-only checks
// - continuous ends on stop or when the set duration elapses
// - stop halts continuous testing until a new continuous command
// - loopback insert-error places exactly one errored bit
// - resync drops alignment and starts a new acquisition
// - statistics reset clears every counter, also while running
// - counter above two billion flags overflow until statistics reset
// - setup ends the session and returns to configuration
// - automatic insertion only with synchronous framing and a nonzero rate
// - toggle flips automatic insertion on and off, rate unchanged
// - local loopback waits for sync then retransmits and checks received data
// - receive-only checks incoming data and transmits nothing
// - duration zero runs until stopped; longest is 97:59:59
// - while out of sync the receive bit and error statistics hold; transmit counts still update in remote mode
module bert_ctrl
    import bert_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = bert_pkg::SECOND_CYCLES,
    parameter int unsigned RATE_W     = 17
) (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rdata,
    output logic             tx_bit,
    output logic             tx_valid,
    input  wire logic        rx_bit_pin,
    input  wire logic        rx_valid_pin,
    output logic      [1:0]  status
);
    import bert_pkg::*;

    initial begin
        if (SEC_CYCLES < 2) $error("SEC_CYCLES too small");
        if (RATE_W < 8) $error("RATE_W too small");
    end

    // receive pins come from outside the clock domain
    logic [1:0] rx_bit_s;
    logic [1:0] rx_vld_s;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_bit_s <= 2'b00;
            rx_vld_s <= 2'b00;
        end else begin
            rx_bit_s <= {rx_bit_s[0], rx_bit_pin};
            rx_vld_s <= {rx_vld_s[0], rx_valid_pin};
        end
    end
    wire rx_bit   = rx_bit_s[1];
    wire rx_valid = rx_vld_s[1];

    // configuration
    logic [7:0]  pat_mem [0:PAT_MAX_LEN-1];
    logic [7:0]  wr_ptr_r;
    logic [7:0]  last_r;
    logic        last_err_r;
    mode_t       mode_r;
    logic        sync_frm_r;
    logic        char5_r;
    logic [15:0] block_len_r;
    logic [19:0] duration_r;
    logic [7:0]  rate_r;
    logic        auto_on_r;

    wire wr_ctrl = wr_en && addr == ADDR_CTRL;
    wire wr_cmd  = wr_en && addr == ADDR_CMD;
    wire wr_pat  = wr_en && addr == ADDR_PAT_DATA;
    wire wr_last = wr_en && addr == ADDR_PAT_LAST;

    wire c_single = wr_cmd && wdata[CMD_SINGLE];
    wire c_cont   = wr_cmd && wdata[CMD_CONT];
    wire c_stop   = wr_cmd && wdata[CMD_STOP];
    wire c_inserr = wr_cmd && wdata[CMD_INSERR];
    wire c_resync = wr_cmd && wdata[CMD_RESYNC];
    wire c_reset  = wr_cmd && wdata[CMD_RESET];
    wire c_setup  = wr_cmd && wdata[CMD_SETUP];
    wire c_errtog = wr_cmd && wdata[CMD_ERRTOG];

    always_ff @(posedge clock) begin
        if (wr_pat) begin
            pat_mem[wr_ptr_r] <= wdata[7:0];
        end
    end

    // pointer wraps after byte 200; the last-byte pointer follows it
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_r   <= 8'h00;
            last_r     <= 8'h02;
            last_err_r <= 1'b0;
        end else if (wr_pat) begin
            wr_ptr_r <= (wr_ptr_r == 8'(PAT_MAX_LEN - 1)) ? 8'h00 : wr_ptr_r + 8'h01;
            last_r   <= wr_ptr_r;
        end else if (wr_last) begin
            if (wdata[7:0] >= 8'(PAT_MIN_LEN - 1) && wdata[7:0] <= 8'(PAT_MAX_LEN - 1)) begin
                last_r     <= wdata[7:0];
                last_err_r <= 1'b0;
            end else begin
                last_err_r <= 1'b1;
            end
        end
    end

    // padded short-character bytes are stored as given and sent whole
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mode_r      <= MODE_REMOTE;
            sync_frm_r  <= 1'b1;
            char5_r     <= 1'b0;
            block_len_r <= BLOCK_LEN_RESET;
            duration_r  <= '0;
            rate_r      <= RATE_NONE;
        end else if (wr_en) begin
            if (addr == ADDR_CTRL && wdata[1:0] != 2'b11) begin
                mode_r     <= mode_t'(wdata[CTRL_MODE_LSB +: 2]);
            end
            if (wr_ctrl) begin
                sync_frm_r <= wdata[CTRL_SYNC_FRM];
                char5_r    <= wdata[CTRL_CHAR5];
            end
            if (addr == ADDR_BLOCK_LEN && wdata[15:0] != 16'h0000) begin
                block_len_r <= wdata[15:0];
            end
            if (addr == ADDR_DURATION && wdata[19:0] <= 20'(MAX_DUR_SECONDS)) begin
                duration_r <= wdata[19:0];
            end
            if (addr == ADDR_RATE) begin
                rate_r <= wdata[7:0];
            end
        end
    end

    wire auto_allowed = sync_frm_r && rate_r != RATE_NONE;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            auto_on_r <= 1'b0;
        end else if (!auto_allowed) begin
            auto_on_r <= 1'b0;
        end else if (c_errtog) begin
            auto_on_r <= ~auto_on_r;
        end
    end

    // run sequencer
    run_t    run_r;
    status_t status_r;
    logic    synced_r;
    logic    ever_sync_r;
    logic [15:0] blk_bits_r;
    logic [2:0]  bit_idx_r;
    logic [7:0]  byte_idx_r;
    logic [19:0] elapsed_r;
    logic        timer_on_r;
    logic [31:0] sec_cnt_r;
    logic        sec_tick;
    logic        dur_done;
    logic        blk_done;

    wire looped  = mode_r != MODE_RECEIVE;
    wire tx_go   = run_r != RUN_OFF && looped
                   && (mode_r == MODE_REMOTE || synced_r);

    assign sec_tick = timer_on_r && sec_cnt_r == 32'(SEC_CYCLES - 1);
    assign dur_done = run_r == RUN_CONT && duration_r != '0
                      && sec_tick && elapsed_r + 20'h1 >= duration_r;
    assign blk_done = run_r == RUN_SINGLE && tx_go && blk_bits_r == block_len_r - 16'h1;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            run_r <= RUN_OFF;
        end else if (c_setup || c_stop) begin
            run_r <= RUN_OFF;
        end else if (c_single && looped) begin
            run_r <= RUN_SINGLE;
        end else if (c_cont) begin
            run_r <= RUN_CONT;
        end else if (blk_done || dur_done) begin
            run_r <= RUN_OFF;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            blk_bits_r <= '0;
        end else if (c_single || c_cont) begin
            blk_bits_r <= '0;
        end else if (tx_go) begin
            blk_bits_r <= blk_bits_r + 16'h1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            timer_on_r <= 1'b0;
            sec_cnt_r  <= '0;
            elapsed_r  <= '0;
        end else begin
            if (c_single || c_cont || c_reset) begin
                sec_cnt_r <= '0;
                elapsed_r <= '0;
                if (c_single || c_cont) begin
                    timer_on_r <= 1'b1;
                end
            end else if (sec_tick) begin
                sec_cnt_r <= '0;
                elapsed_r <= elapsed_r + 20'h1;
            end else if (timer_on_r) begin
                sec_cnt_r <= sec_cnt_r + 32'h1;
            end
            if (c_stop || c_setup || blk_done || dur_done) begin
                timer_on_r <= 1'b0;
            end
        end
    end

    // transmit pattern walk, the pattern wraps after the last-byte pointer
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bit_idx_r  <= 3'h0;
            byte_idx_r <= 8'h00;
        end else if (c_single || c_cont) begin
            bit_idx_r  <= 3'h0;
            byte_idx_r <= 8'h00;
        end else if (tx_go && mode_r == MODE_REMOTE) begin
            bit_idx_r <= bit_idx_r + 3'h1;
            if (bit_idx_r == 3'h7) begin
                byte_idx_r <= (byte_idx_r == last_r) ? 8'h00 : byte_idx_r + 8'h01;
            end
        end
    end

    // error injection: manual pulse or rate-based
    logic            err_pend_r;
    logic [RATE_W-1:0] rate_cnt_r;
    wire rate_hit = auto_on_r && rate_cnt_r >= RATE_W'(rate_r) * RATE_W'(8); // coarse rate divider
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rate_cnt_r <= '0;
        end else if (!auto_on_r || (tx_go && rate_hit)) begin
            rate_cnt_r <= '0;
        end else if (tx_go) begin
            rate_cnt_r <= rate_cnt_r + 1'b1;
        end
    end

    // a pending manual error waits for the next sent bit
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            err_pend_r <= 1'b0;
        end else if (c_inserr && looped) begin
            err_pend_r <= 1'b1;
        end else if (tx_go) begin
            err_pend_r <= 1'b0;
        end
    end

    wire inject  = tx_go && (err_pend_r || rate_hit);
    wire pat_bit = pat_mem[byte_idx_r][3'h7 - bit_idx_r];
    wire src_bit = (mode_r == MODE_LOCAL) ? rx_bit : pat_bit;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tx_bit   <= 1'b0;
            tx_valid <= 1'b0;
        end else begin
            tx_valid <= tx_go && (mode_r == MODE_REMOTE || rx_valid);
            tx_bit   <= tx_go ? (src_bit ^ inject) : 1'b0;
        end
    end

    // receive checker: simple pattern alignment, retried while out of sync
    logic [7:0] rx_byte_r;
    logic [2:0] rx_bit_idx_r;
    logic [3:0] good_r;
    wire rx_active = run_r != RUN_OFF && rx_valid;
    wire exp_bit   = pat_mem[rx_byte_r][3'h7 - rx_bit_idx_r];
    wire rx_err    = rx_bit != exp_bit;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            synced_r     <= 1'b0;
            good_r       <= 4'h0;
            rx_byte_r    <= 8'h00;
            rx_bit_idx_r <= 3'h0;
        end else if (c_resync || run_r == RUN_OFF) begin
            synced_r     <= 1'b0;
            good_r       <= 4'h0;
            rx_byte_r    <= 8'h00;
            rx_bit_idx_r <= 3'h0;
        end else if (rx_active) begin
            rx_bit_idx_r <= rx_bit_idx_r + 3'h1;
            if (rx_bit_idx_r == 3'h7) begin
                rx_byte_r <= (rx_byte_r == last_r) ? 8'h00 : rx_byte_r + 8'h01;
            end
            if (!synced_r) begin
                if (rx_err) begin
                    good_r       <= 4'h0;
                    rx_byte_r    <= 8'h00;
                    rx_bit_idx_r <= 3'h0;
                end else if (good_r == 4'hf) begin
                    synced_r <= 1'b1;
                end else begin
                    good_r <= good_r + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ever_sync_r <= 1'b0;
        end else if (c_single || c_cont || c_setup) begin
            ever_sync_r <= 1'b0;
        end else if (synced_r) begin
            ever_sync_r <= 1'b1;
        end
    end

    always_comb begin
        unique case (run_r)
            RUN_SINGLE, RUN_CONT: status_r = synced_r ? ST_IN_SYNC : ST_NO_SYNC;
            default:              status_r = ST_IDLE;
        endcase
    end
    assign status = status_r;

    // statistics
    localparam int NSTAT = 5;
    logic [NSTAT-1:0] st_inc;
    logic [31:0]      st_cnt [0:NSTAT-1];
    logic [NSTAT-1:0] st_ovf;
    wire  stats_clr = c_reset || c_setup;
    wire  rx_count  = rx_active && synced_r;
    logic sync_q_r;
    logic sync_drop;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sync_q_r <= 1'b0;
        end else begin
            sync_q_r <= synced_r;
        end
    end
    assign sync_drop = sync_q_r && !synced_r;
    wire  sync_lost = ever_sync_r && sync_drop;

    assign st_inc[0] = tx_valid;
    assign st_inc[1] = inject;
    assign st_inc[2] = rx_count;
    assign st_inc[3] = rx_count && rx_err;
    assign st_inc[4] = sync_lost && run_r != RUN_OFF;

    genvar gi;
    generate
        for (gi = 0; gi < NSTAT; gi++) begin : g_stat
            stat_counter #(.W(32)) u_cnt (
                .clock    (clock),
                .reset_n  (reset_n),
                .clear    (stats_clr),
                .inc      (st_inc[gi]),
                .limit    (OVF_LIMIT),
                .count    (st_cnt[gi]),
                .overflow (st_ovf[gi])
            );
        end
    endgenerate

    function automatic logic [31:0] stat_word(input int idx);
        stat_word = st_ovf[idx] ? 32'hffff_ffff : st_cnt[idx];
    endfunction

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 32'h0000_0000;
        end else if (rd_en) begin
            unique case (addr)
                ADDR_CTRL:      rdata <= {28'h0, char5_r, sync_frm_r, mode_r};
                ADDR_PAT_LAST:  rdata <= {23'h0, last_err_r, last_r};
                ADDR_BLOCK_LEN: rdata <= {16'h0, block_len_r};
                ADDR_DURATION:  rdata <= {12'h0, duration_r};
                ADDR_RATE:      rdata <= {23'h0, auto_on_r, rate_r};
                ADDR_STATUS:    rdata <= {23'h0, st_ovf, run_r, status_r};
                ADDR_ELAPSED:   rdata <= {12'h0, elapsed_r};
                ADDR_TX_BITS:   rdata <= stat_word(0);
                ADDR_TX_ERRS:   rdata <= stat_word(1);
                ADDR_RX_BITS:   rdata <= stat_word(2);
                ADDR_RX_ERRS:   rdata <= stat_word(3);
                ADDR_SYNC_LOSS: rdata <= stat_word(4);
                ADDR_PAT_PTR:   rdata <= {24'h0, wr_ptr_r};
                default:        rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end
endmodule

// ### bench/bert_ctrl_sva.sv
// checker: port-level assertions for the test controller
`timescale 1ns/10ps
module bert_ctrl_sva
    import bert_pkg::*;
(
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [31:0] rdata,
    input wire logic        tx_bit,
    input wire logic        tx_valid,
    input wire logic        rx_bit_pin,
    input wire logic        rx_valid_pin,
    input wire logic [1:0]  status
);
    logic [1:0] mode_r;
    logic [1:0] age_r;
    logic       cmd_w;
    assign cmd_w = wr_en && (addr == ADDR_CMD);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // shadow of the mode field; mode 3 is refused by the block
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n)
            mode_r <= MODE_REMOTE;
        else if (wr_en && addr == ADDR_CTRL && wdata[1:0] != 2'b11)
            mode_r <= wdata[1:0];
    end
    // settle time after a mode write so a stream in flight is not judged
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n)
            age_r <= 2'd0;
        else if (wr_en && addr == ADDR_CTRL)
            age_r <= 2'd0;
        else if (age_r != 2'd3)
            age_r <= age_r + 2'd1;
    end
    AST_STATUS_LEGAL: assert property (status != 2'b11)
        else $error("status code out of range");
    AST_NO_JUMP_TO_SYNC: assert property (status == ST_IDLE |=> status != ST_IN_SYNC)
        else $error("sync reached without acquisition");
    AST_CONT_RUNS: assert property (cmd_w && wdata[CMD_CONT] |-> ##[1:2] status != ST_IDLE)
        else $error("continuous command left status idle");
    AST_REMOTE_TX: assert property (
        cmd_w && wdata[CMD_CONT] && mode_r == MODE_REMOTE && age_r == 2'd3 |-> ##[1:3] tx_valid)
        else $error("remote continuous did not transmit");
    AST_RECV_SILENT: assert property (mode_r == MODE_RECEIVE && age_r == 2'd3 |-> !tx_valid)
        else $error("transmit in receive-only mode");
    AST_STOP_HALTS: assert property (
        cmd_w && wdata[CMD_STOP] && !wdata[CMD_CONT] && !wdata[CMD_SINGLE]
        |-> ##[1:3] !tx_valid ##1 !tx_valid [*4])
        else $error("transmit after stop");
    AST_SETUP_IDLE: assert property (cmd_w && wdata[CMD_SETUP] |-> ##[1:3] status == ST_IDLE)
        else $error("setup did not end the session");
    AST_RESYNC_DROP: assert property (
        cmd_w && wdata[CMD_RESYNC] && status == ST_IN_SYNC |-> ##[1:3] status == ST_NO_SYNC)
        else $error("resync kept alignment");
endmodule
bind bert_ctrl bert_ctrl_sva bert_ctrl_sva_inst (.*);

// ### bench/bert_far_end.sv
// far end model: looped-back line equipment echoing the transmitted stream
`timescale 1ns/10ps
module bert_far_end (
    input  wire logic clock,
    input  wire logic loop_en,
    input  wire logic tx_bit,
    input  wire logic tx_valid,
    output logic      rx_bit_pin,
    output logic      rx_valid_pin
);
    initial begin
        rx_bit_pin = 1'b0;
        rx_valid_pin = 1'b0;
    end
    // idle line shows the inverse of its last bit so no stale value passes
    always @(posedge clock) begin
        rx_valid_pin <= loop_en && tx_valid;
        rx_bit_pin   <= (loop_en && tx_valid) ? tx_bit : ~rx_bit_pin;
    end
endmodule

// ### bench/bert_ctrl_tb.sv
// testbench: register-driven scenarios for the test controller
`timescale 1ns/10ps
`define CHK(a, e) check_val(a, e)
module bert_ctrl_tb;
    import bert_pkg::*;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic        loop_en = 1'b1;
    logic [31:0] rdata;
    logic        tx_bit, tx_valid, rx_bit_pin, rx_valid_pin;
    logic [1:0]  status;
    logic [31:0] d;
    int          n_fail = 0;
    int          total_checks = 0;
    always #2 clock = ~clock;
    bert_ctrl #(.SEC_CYCLES(100)) bert_ctrl_inst (.clock(clock), .reset_n(reset_n), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .tx_bit(tx_bit),
        .tx_valid(tx_valid), .rx_bit_pin(rx_bit_pin), .rx_valid_pin(rx_valid_pin), .status(status));
    bert_far_end bert_far_end_inst (.clock(clock), .loop_en(loop_en), .tx_bit(tx_bit),
        .tx_valid(tx_valid), .rx_bit_pin(rx_bit_pin), .rx_valid_pin(rx_valid_pin));
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check_val(input logic [31:0] a, input logic [31:0] e);
        total_checks++;
        if (a !== e) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, a, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic cmd(input int n);
        wr(ADDR_CMD, 32'h0000_0001 << n);
    endtask
    // bounded wait; running out counts as a mismatch and ends the run
    task automatic wait_st(input logic [1:0] st);
        for (int i = 0; i < 2000 && status !== st; i++)
            @(posedge clock);
        if (status !== st) begin
            n_fail++;
            final_report();
        end
    endtask
    task automatic t_pattern();
        logic [7:0] pat [3] = '{8'ha8, 8'h8d, 8'hf0};
        int n = 0;
        wr(ADDR_CTRL, 32'h0000_0008);
        foreach (pat[i]) wr(ADDR_PAT_DATA, {24'h00_0000, pat[i]});
        wr(ADDR_BLOCK_LEN, 32'h0000_0030);
        cmd(CMD_SINGLE);
        repeat (200) begin
            @(posedge clock);
            #1;
            if (tx_valid === 1'b1) begin
                `CHK(tx_bit, pat[(n / 8) % 3][7 - n % 8]);
                n++;
            end
        end
        `CHK(n, 48);
        `CHK(status, ST_IDLE);
        wr(ADDR_PAT_LAST, 32'h0000_0001);
        rd(ADDR_PAT_LAST, d);
        `CHK(d[8], 1'b1);
        `CHK(d[7:0], 8'h02);
        wr(ADDR_PAT_LAST, 32'h0000_00c7);
        rd(ADDR_PAT_LAST, d);
        `CHK(d[7:0], 8'hc7);
        repeat (198) wr(ADDR_PAT_DATA, 32'h0000_005a);
        rd(ADDR_PAT_PTR, d);
        `CHK(d, 32'h0000_0001);
        wr(ADDR_PAT_LAST, 32'h0000_0002);
        $display("t_pattern done");
    endtask
    task automatic t_cont();
        wr(ADDR_CTRL, 32'h0000_0000);
        wr(ADDR_DURATION, 32'h0000_0000);
        cmd(CMD_CONT);
        wait_st(ST_IN_SYNC);
        repeat (250) @(posedge clock);
        rd(ADDR_ELAPSED, d);
        `CHK(d, 32'h0000_0002);
        cmd(CMD_STOP);
        repeat (150) @(posedge clock);
        rd(ADDR_ELAPSED, d);
        `CHK(d, 32'h0000_0002);
        wr(ADDR_DURATION, 32'h0000_0002);
        cmd(CMD_CONT);
        wait_st(ST_IN_SYNC);
        wait_st(ST_IDLE);
        rd(ADDR_ELAPSED, d);
        `CHK(d, 32'h0000_0002);
        wr(ADDR_DURATION, 32'h0005_621f);
        wr(ADDR_DURATION, 32'h0005_6220);
        rd(ADDR_DURATION, d);
        `CHK(d, 32'h0005_621f);
        wr(ADDR_DURATION, 32'h0000_0000);
        $display("t_cont done");
    endtask
    task automatic t_err();
        cmd(CMD_CONT);
        wait_st(ST_IN_SYNC);
        cmd(CMD_RESET);
        cmd(CMD_INSERR);
        repeat (10) @(posedge clock);
        rd(ADDR_TX_ERRS, d);
        `CHK(d, 32'h0000_0001);
        cmd(CMD_RESET);
        rd(ADDR_TX_ERRS, d);
        `CHK(d, 32'h0000_0000);
        rd(ADDR_ELAPSED, d);
        `CHK(d, 32'h0000_0000);
        wait_st(ST_IN_SYNC);
        cmd(CMD_RESYNC);
        #1;
        `CHK(status, ST_NO_SYNC);
        wait_st(ST_IN_SYNC);
        cmd(CMD_STOP);
        $display("t_err done");
    endtask
    task automatic t_rate();
        wr(ADDR_RATE, 32'h0000_0003);
        cmd(CMD_ERRTOG);
        rd(ADDR_RATE, d);
        `CHK(d, 32'h0000_0003);
        wr(ADDR_CTRL, 32'h0000_0004);
        wr(ADDR_RATE, 32'h0000_0000);
        cmd(CMD_ERRTOG);
        rd(ADDR_RATE, d);
        `CHK(d, 32'h0000_0000);
        wr(ADDR_RATE, 32'h0000_0003);
        cmd(CMD_ERRTOG);
        rd(ADDR_RATE, d);
        `CHK(d, 32'h0000_0103);
        cmd(CMD_ERRTOG);
        rd(ADDR_RATE, d);
        `CHK(d, 32'h0000_0003);
        $display("t_rate done");
    endtask
    task automatic t_modes();
        wr(ADDR_CTRL, 32'h0000_0002);
        wr(ADDR_CTRL, 32'h0000_0003);
        wr(8'h3f, 32'h0000_0001);
        rd(ADDR_CTRL, d);
        `CHK(d[1:0], MODE_RECEIVE);
        cmd(CMD_CONT);
        repeat (50) @(posedge clock);
        `CHK(status, ST_NO_SYNC);
        cmd(CMD_SETUP);
        rd(ADDR_RX_BITS, d);
        `CHK(status, ST_IDLE);
        `CHK(d, 32'h0000_0000);
        $display("t_modes done");
    endtask
    initial begin
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        t_pattern();
        t_cont();
        t_err();
        t_rate();
        t_modes();
        final_report();
    end
endmodule
